// file: verilog/eic_pkg.sv
package eic_pkg;

    // Bus geometry: every printed offset is a register index, byte address is four times it
    localparam int          ADDR_W           = 18;
    localparam int          DATA_W           = 32;
    localparam int          IDX_W            = 16;

    // Register indices
    localparam logic [15:0] IDX_PERIPH_EN    = 16'hf024;
    localparam logic [15:0] IDX_P3X_IC       = 16'hf19e;
    localparam logic [15:0] IDX_SRC_SEL      = 16'hf100;
    localparam logic [15:0] IDX_EDGE_SEL     = 16'hf101;
    localparam logic [15:0] IDX_CH_IC0       = 16'hf110;
    localparam logic [15:0] IDX_IRQ_STATUS   = 16'hf120;
    localparam logic [15:0] IDX_IRQ_CLEAR    = 16'hf121;
    localparam logic [15:0] IDX_IRQ_ENABLE   = 16'hf122;

    // Interrupt control word layout
    localparam int          IC_FLAG_BIT      = 7;
    localparam int          IC_EN_BIT        = 6;
    localparam int          IC_LVL_LSB       = 2;
    localparam int          IC_GRP_LSB       = 0;
    localparam logic [15:0] IC_USED_MASK     = 16'h00ff;

    // Peripheral enable bits
    localparam int          PE_W             = 5;
    localparam int          PE_FIRST_CAN     = 0;
    localparam int          PE_SECOND_CAN    = 1;
    localparam int          PE_SMALL_RAM     = 2;
    localparam int          PE_LARGE_RAM     = 3;
    localparam int          PE_RTC           = 4;

    // Reset values
    localparam logic [15:0] RST_IC           = 16'h0000;
    localparam logic [15:0] RST_SRC_SEL      = 16'h0000;
    localparam logic [15:0] RST_EDGE_SEL     = 16'h0000;
    localparam logic [4:0]  RST_PERIPH_EN    = 5'h05;

    // Source selection codes
    localparam logic [1:0]  SEL_PIN          = 2'h0;
    localparam logic [1:0]  SEL_ALT          = 2'h1;
    localparam logic [1:0]  SEL_OR           = 2'h2;
    localparam logic [1:0]  SEL_AND          = 2'h3;

    // Edge selection codes
    localparam logic [1:0]  EDGE_STD         = 2'h0;
    localparam logic [1:0]  EDGE_RISE        = 2'h1;
    localparam logic [1:0]  EDGE_FALL        = 2'h2;
    localparam logic [1:0]  EDGE_ANY         = 2'h3;

    // Small extension RAM window
    localparam logic [23:0] SMALL_RAM_LO     = 24'h00_e000;
    localparam logic [23:0] SMALL_RAM_HI     = 24'h00_e7ff;

endpackage

// file: verilog/eic_top.sv
`timescale 1ns/1ps
module eic_top #(
    parameter int N_CH = 8
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // Avalon-MM slave
    input  wire logic [eic_pkg::ADDR_W-1:0]    address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [3:0]                    byteenable,
    input  wire logic [eic_pkg::DATA_W-1:0]    writedata,
    output logic      [eic_pkg::DATA_W-1:0]    readdata,
    output logic                               waitrequest,
    // Interrupt sources
    input  wire logic [N_CH-1:0]               port_pin,
    input  wire logic                          first_can_receive_line,
    input  wire logic                          second_can_receive_line,
    input  wire logic                          rtc_second_event,
    input  wire logic                          rtc_alarm_event,
    input  wire logic                          port3_extra_event,
    // Arbitration request towards the CPU
    output logic                               int_req,
    output logic      [3:0]                    int_level,
    output logic      [1:0]                    int_group,
    output logic      [3:0]                    int_src,
    input  wire logic                          int_ack,
    output logic                               irq,
    // Peripheral enables and memory routing
    input  wire logic                          global_ext_peripheral_enable,
    input  wire logic [23:0]                   mem_addr,
    output logic      [eic_pkg::PE_W-1:0]      peripheral_enable,
    output logic                               ext_mem_sel
);

    localparam int N_SRC = N_CH + 1;

    // The alternate source map is fixed to eight channels
    if (N_CH != 8)
    begin : g_bad_nch
        $error("eic_top supports exactly eight channels");
    end

    logic [15:0]            src_sel_q;
    logic [15:0]            edge_sel_q;
    logic [7:0]             ic_q [N_SRC];
    logic [N_SRC-1:0]       ists_q;
    logic [N_SRC-1:0]       ien_q;
    logic [eic_pkg::PE_W-1:0] pe_q;
    logic [N_CH-1:0]        ch_in;
    logic [N_CH-1:0]        ch_prev_q;
    logic [N_CH-1:0]        alt_src;
    logic [N_CH-1:0]        hit;
    logic [N_SRC-1:0]       hw_set;
    logic [N_SRC-1:0]       ic_wr;
    logic [N_SRC-1:0]       ack_clr;
    logic [15:0]            idx;
    logic                   wr_acc;
    logic                   rd_take;
    logic [31:0]            rd_d;
    logic [31:0]            rd_q;
    logic                   wait_q;
    logic                   best_v;
    logic [3:0]             best_i;
    logic [5:0]             best_key;
    logic                   int_req_q;
    logic [3:0]             int_level_q;
    logic [1:0]             int_group_q;
    logic [3:0]             int_src_q;
    logic                   irq_q;
    logic                   ext_mem_q;

    // Byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd, input logic [3:0] be);
        logic [15:0] r;
        r = old_v;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction

    assign idx     = address[eic_pkg::ADDR_W-1:2];
    assign wr_acc  = write && !wait_q;
    assign rd_take = read && wait_q;

    // Alternate sources; upper channels have none
    assign alt_src = {4'h0, rtc_alarm_event, rtc_second_event, second_can_receive_line, first_can_receive_line};

    // Channel input selection
    always_comb
    begin
        for (int i = 0; i < N_CH; i++)
        begin
            case (src_sel_q[2*i +: 2])
                eic_pkg::SEL_PIN: ch_in[i] = port_pin[i];
                eic_pkg::SEL_ALT: ch_in[i] = alt_src[i];
                eic_pkg::SEL_OR:  ch_in[i] = port_pin[i] | alt_src[i];
                eic_pkg::SEL_AND: ch_in[i] = port_pin[i] & alt_src[i];
                default:          ch_in[i] = port_pin[i];
            endcase
        end
    end

    // Previous channel levels for edge detection
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ch_prev_q <= '0;
        else
            ch_prev_q <= ch_in;
    end

    // Edge detection; standard mode reacts to rising edges like a plain external line
    always_comb
    begin
        for (int i = 0; i < N_CH; i++)
        begin
            case (edge_sel_q[2*i +: 2])
                eic_pkg::EDGE_STD:  hit[i] = ch_in[i] & ~ch_prev_q[i];
                eic_pkg::EDGE_RISE: hit[i] = ch_in[i] & ~ch_prev_q[i];
                eic_pkg::EDGE_FALL: hit[i] = ~ch_in[i] & ch_prev_q[i];
                eic_pkg::EDGE_ANY:  hit[i] = ch_in[i] ^ ch_prev_q[i];
                default:            hit[i] = 1'b0;
            endcase
        end
    end

    assign hw_set = {port3_extra_event, hit};

    // Write strobes for the control words; the port-3 extra word sits last
    always_comb
    begin
        for (int i = 0; i < N_CH; i++)
            ic_wr[i] = wr_acc && byteenable[0] && (idx == eic_pkg::IDX_CH_IC0 + 16'(i));
        ic_wr[N_CH] = wr_acc && byteenable[0] && (idx == eic_pkg::IDX_P3X_IC);
        ack_clr = '0;
        if (int_ack && int_req_q)
            ack_clr[int_src_q] = 1'b1;
    end

    // Control words; a source event wins over a software or acknowledge clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < N_SRC; i++)
                ic_q[i] <= eic_pkg::RST_IC[7:0];
        end
        else
        begin
            for (int i = 0; i < N_SRC; i++)
            begin
                if (ic_wr[i])
                    ic_q[i][6:0] <= writedata[6:0];
                if (hw_set[i])
                    ic_q[i][eic_pkg::IC_FLAG_BIT] <= 1'b1;
                else if (ic_wr[i])
                    ic_q[i][eic_pkg::IC_FLAG_BIT] <= writedata[eic_pkg::IC_FLAG_BIT];
                else if (ack_clr[i])
                    ic_q[i][eic_pkg::IC_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // Source and edge selection registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            src_sel_q  <= eic_pkg::RST_SRC_SEL;
            edge_sel_q <= eic_pkg::RST_EDGE_SEL;
        end
        else if (wr_acc)
        begin
            if (idx == eic_pkg::IDX_SRC_SEL)
                src_sel_q <= merge16(src_sel_q, writedata, byteenable);
            if (idx == eic_pkg::IDX_EDGE_SEL)
                edge_sel_q <= merge16(edge_sel_q, writedata, byteenable);
        end
    end

    // Peripheral enables freeze once the global extension enable is up
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pe_q <= eic_pkg::RST_PERIPH_EN;
        else if (wr_acc && byteenable[0] && idx == eic_pkg::IDX_PERIPH_EN && !global_ext_peripheral_enable)
            pe_q <= writedata[eic_pkg::PE_W-1:0];
    end

    // Small RAM window goes off-chip while that RAM is disabled
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ext_mem_q <= 1'b0;
        else
            ext_mem_q <= !pe_q[eic_pkg::PE_SMALL_RAM] && mem_addr >= eic_pkg::SMALL_RAM_LO
                         && mem_addr <= eic_pkg::SMALL_RAM_HI;
    end

    // Arbitration: highest priority, then group, then lowest index
    always_comb
    begin
        best_v   = 1'b0;
        best_i   = 4'h0;
        best_key = 6'h00;
        for (int i = 0; i < N_SRC; i++)
        begin
            if (ic_q[i][eic_pkg::IC_FLAG_BIT] && ic_q[i][eic_pkg::IC_EN_BIT]
                && (!best_v || ic_q[i][5:0] > best_key))
            begin
                best_v   = 1'b1;
                best_i   = 4'(i);
                best_key = ic_q[i][5:0];
            end
        end
    end

    // Registered request towards the CPU
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            int_req_q   <= 1'b0;
            int_level_q <= 4'h0;
            int_group_q <= 2'h0;
            int_src_q   <= 4'h0;
        end
        else
        begin
            int_req_q   <= best_v && !(ack_clr[best_i]);
            int_level_q <= best_key[5:2];
            int_group_q <= best_key[1:0];
            int_src_q   <= best_i;
        end
    end

    // Sticky event status, write-one-to-clear; a new event wins over the clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ists_q <= '0;
            ien_q  <= '0;
            irq_q  <= 1'b0;
        end
        else
        begin
            if (wr_acc && idx == eic_pkg::IDX_IRQ_CLEAR)
                ists_q <= (ists_q & ~writedata[N_SRC-1:0]) | hw_set;
            else
                ists_q <= ists_q | hw_set;
            if (wr_acc && idx == eic_pkg::IDX_IRQ_ENABLE)
                ien_q <= writedata[N_SRC-1:0];
            irq_q <= |(ists_q & ien_q);
        end
    end

    // Read multiplexer; unmapped and write-only words read zero
    always_comb
    begin
        rd_d = 32'h0000_0000;
        for (int i = 0; i < N_CH; i++)
            if (idx == eic_pkg::IDX_CH_IC0 + 16'(i))
                rd_d[7:0] = ic_q[i];
        case (idx)
            eic_pkg::IDX_P3X_IC:     rd_d[7:0] = ic_q[N_CH];
            eic_pkg::IDX_PERIPH_EN:  rd_d[eic_pkg::PE_W-1:0] = pe_q;
            eic_pkg::IDX_SRC_SEL:    rd_d[15:0] = src_sel_q;
            eic_pkg::IDX_EDGE_SEL:   rd_d[15:0] = edge_sel_q;
            eic_pkg::IDX_IRQ_STATUS: rd_d[N_SRC-1:0] = ists_q;
            eic_pkg::IDX_IRQ_ENABLE: rd_d[N_SRC-1:0] = ien_q;
            default:                 ;
        endcase
    end

    // One wait cycle per access: data is latched while waitrequest is still high
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_q <= 1'b1;
            rd_q   <= 32'h0000_0000;
        end
        else
        begin
            wait_q <= !((read || write) && wait_q);
            if (rd_take)
                rd_q <= rd_d;
        end
    end

    assign readdata          = rd_q;
    assign waitrequest       = wait_q;
    assign int_req           = int_req_q;
    assign int_level         = int_level_q;
    assign int_group         = int_group_q;
    assign int_src           = int_src_q;
    assign irq               = irq_q;
    assign peripheral_enable = pe_q;
    assign ext_mem_sel       = ext_mem_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_SEL_PIN: assert property ((src_sel_q[1:0] == eic_pkg::SEL_PIN) |-> ch_in[0] == port_pin[0])
        else $error("pin select does not follow pin");
    AST_SEL_ALT: assert property ((src_sel_q[3:2] == eic_pkg::SEL_ALT) |-> ch_in[1] == second_can_receive_line)
        else $error("alternate select does not follow source");
    AST_SEL_OR: assert property ((src_sel_q[5:4] == eic_pkg::SEL_OR)
        |-> ch_in[2] == (port_pin[2] | rtc_second_event))
        else $error("or select mismatch");
    AST_SEL_AND: assert property ((src_sel_q[7:6] == eic_pkg::SEL_AND)
        |-> ch_in[3] == (port_pin[3] & rtc_alarm_event))
        else $error("and select mismatch");
    AST_ALT_ZERO: assert property ((src_sel_q[11:10] == eic_pkg::SEL_ALT) |-> !ch_in[5])
        else $error("upper channel alternate not zero");
    AST_FALL_SETS: assert property ((edge_sel_q[9:8] == eic_pkg::EDGE_FALL && ch_prev_q[4] && !ch_in[4])
        |=> ic_q[4][eic_pkg::IC_FLAG_BIT])
        else $error("falling edge did not set flag");
    AST_FLAG_WRITE: assert property ((ic_wr[N_CH] && writedata[eic_pkg::IC_FLAG_BIT])
        |=> ic_q[N_CH][eic_pkg::IC_FLAG_BIT])
        else $error("software flag write lost");
    // The winner index is taken from the edge that loaded the request, not the one after
    AST_GRANT_ENABLED: assert property (int_req_q |-> $past(ic_q[best_i][eic_pkg::IC_EN_BIT]))
        else $error("disabled source granted");
    AST_GRANT_LEVEL: assert property (best_v |-> ic_q[best_i][5:0] >= ic_q[N_CH][5:0]
        || !(ic_q[N_CH][7] && ic_q[N_CH][6]))
        else $error("lower priority source chosen");
    AST_PE_LOCK: assert property (global_ext_peripheral_enable |=> $stable(pe_q))
        else $error("peripheral enables changed while locked");
    AST_SMALL_RAM: assert property ((!pe_q[eic_pkg::PE_SMALL_RAM] && mem_addr == eic_pkg::SMALL_RAM_LO)
        |=> ext_mem_sel)
        else $error("small RAM window not sent off-chip");
    AST_BUS_ONE_WAIT: assert property ((read || write) && wait_q |=> !wait_q ##1 wait_q)
        else $error("bus answer not after one wait cycle");

endmodule

// file: verif/eic_cpu_model.sv
`timescale 1ns/1ps
// Stand-in for the CPU arbiter: acknowledges the presented winner after a set wait
module eic_cpu_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Request from the controller
    input  wire logic       int_req,
    input  wire logic [3:0] int_src,
    // Behaviour control from the bench
    input  wire logic       ack_on,
    input  wire logic [3:0] ack_wait,
    // Answer
    output logic            int_ack,
    output logic      [3:0] acked_src
);
    logic [3:0] wait_q;

    // One-cycle ack; no ack in the cycle after one, so a stale request can drain
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_q    <= 4'h0;
            int_ack   <= 1'b0;
            acked_src <= 4'h0;
        end
        else
        begin
            int_ack <= 1'b0;
            if (ack_on && int_req && !int_ack)
            begin
                if (wait_q == ack_wait)
                begin
                    int_ack   <= 1'b1;
                    acked_src <= int_src;
                    wait_q    <= 4'h0;
                end
                else
                    wait_q <= wait_q + 4'h1;
            end
            else
                wait_q <= 4'h0;
        end
    end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk, rstn, read, write, int_req, int_ack, irq, gpe, ext_sel, ack_on;
    logic        can1, can2, rtcs, rtca, p3ev, waitrequest;
    logic [17:0] address;
    logic [3:0]  byteenable, int_level, int_src, ack_wait, acked_src;
    logic [31:0] writedata, readdata, rv;
    logic [7:0]  port_pin;
    logic [1:0]  int_group;
    logic [23:0] mem_addr;
    logic [4:0]  pe_out;
    int          err_total, num_checks;

    eic_top dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .port_pin(port_pin), .first_can_receive_line(can1), .second_can_receive_line(can2),
        .rtc_second_event(rtcs), .rtc_alarm_event(rtca), .port3_extra_event(p3ev), .int_req(int_req),
        .int_level(int_level), .int_group(int_group), .int_src(int_src), .int_ack(int_ack), .irq(irq),
        .global_ext_peripheral_enable(gpe), .mem_addr(mem_addr), .peripheral_enable(pe_out),
        .ext_mem_sel(ext_sel));

    eic_cpu_model cpu (.clk(clk), .rstn(rstn), .int_req(int_req), .int_src(int_src), .ack_on(ack_on),
        .ack_wait(ack_wait), .int_ack(int_ack), .acked_src(acked_src));

    // Clock at 100 MHz
    always #5 clk = ~clk;

    // Comparisons, one per kind of result
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    // Avalon transfer: request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge clk);
        address   <= {idx, 2'b00};
        writedata <= wd;
        write     <= wr;
        read      <= !wr;
        // No local limit: only the watchdog ends a hung transfer
        do
            @(posedge clk);
        while (waitrequest !== 1'b0);
        rv = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h0000_0000);
        chk_word(what, exp, rv);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic t_reset;
        rdchk(eic_pkg::IDX_PERIPH_EN, 32'h0000_0005, "periph reset");
        chk_word("periph out", 32'h0000_0005, {27'h0, pe_out});
        rdchk(eic_pkg::IDX_CH_IC0, 32'h0000_0000, "control reset");
        rdchk(eic_pkg::IDX_SRC_SEL, 32'h0000_0000, "select reset");
    endtask

    // Upper bits unused, then frozen while the global enable is up, then window routing
    task automatic t_periph;
        logic [23:0] ma [4];
        ma = '{24'h00_e000, 24'h00_e7ff, 24'h00_e800, 24'h00_dfff};
        wr(eic_pkg::IDX_PERIPH_EN, 32'h0000_ffff);
        rdchk(eic_pkg::IDX_PERIPH_EN, 32'h0000_001f, "periph bits");
        @(posedge clk) gpe <= 1'b1;
        wr(eic_pkg::IDX_PERIPH_EN, 32'h0000_0000);
        rdchk(eic_pkg::IDX_PERIPH_EN, 32'h0000_001f, "periph frozen");
        @(posedge clk) gpe <= 1'b0;
        wr(eic_pkg::IDX_PERIPH_EN, 32'h0000_0001);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk) mem_addr <= ma[i];
            tick(2);
            chk_bit("external select", i < 2, ext_sel);
        end
        wr(eic_pkg::IDX_PERIPH_EN, 32'h0000_0005);
        @(posedge clk) mem_addr <= ma[0];
        tick(2);
        chk_bit("external select", 1'b0, ext_sel);
    endtask

    // Every select code against every non-idle pin/alternate pair on channel 0
    task automatic t_select;
        logic p, a, e;
        for (int s = 0; s < 4; s++)
            for (int c = 1; c < 4; c++)
            begin
                p = c[1];
                a = c[0];
                e = (s == 0) ? p : (s == 1) ? a : (s == 2) ? (p | a) : (p & a);
                @(posedge clk);
                port_pin[0] <= 1'b0;
                can1        <= 1'b0;
                wr(eic_pkg::IDX_SRC_SEL, 32'(s * 16'h5555));
                wr(eic_pkg::IDX_EDGE_SEL, 32'h0000_0001);
                wr(eic_pkg::IDX_CH_IC0, 32'h0000_0000);
                @(posedge clk);
                port_pin[0] <= p;
                can1        <= a;
                tick(2);
                bus(1'b0, eic_pkg::IDX_CH_IC0, 32'h0000_0000);
                chk_bit("select flag", e, rv[7]);
            end
        @(posedge clk) port_pin[0] <= 1'b0;
        can1 <= 1'b0;
    endtask

    // Alternates only, pins raised as well to show they are ignored
    task automatic t_alt;
        wr(eic_pkg::IDX_SRC_SEL, 32'h0000_5555);
        wr(eic_pkg::IDX_EDGE_SEL, 32'h0000_5555);
        for (int i = 0; i < 8; i++)
            wr(eic_pkg::IDX_CH_IC0 + 16'(i), 32'h0000_0000);
        @(posedge clk);
        {can1, can2, rtcs, rtca} <= 4'hf;
        port_pin <= 8'hff;
        tick(2);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, eic_pkg::IDX_CH_IC0 + 16'(i), 32'h0000_0000);
            chk_bit("alternate flag", i < 4, rv[7]);
        end
        @(posedge clk);
        {can1, can2, rtcs, rtca} <= 4'h0;
        port_pin <= 8'h00;
        wr(eic_pkg::IDX_SRC_SEL, 32'h0000_0000);
    endtask

    // Each edge mode on channel 4, rise then fall
    task automatic t_edge;
        for (int m = 0; m < 4; m++)
        begin
            wr(eic_pkg::IDX_EDGE_SEL, 32'(m << 8));
            wr(eic_pkg::IDX_CH_IC0 + 16'h4, 32'h0000_0000);
            @(posedge clk) port_pin[4] <= 1'b1;
            tick(2);
            rdchk(eic_pkg::IDX_CH_IC0 + 16'h4, (m != 2) ? 32'h0000_0080 : 32'h0, "rise flag");
            wr(eic_pkg::IDX_CH_IC0 + 16'h4, 32'h0000_0000);
            @(posedge clk) port_pin[4] <= 1'b0;
            tick(2);
            rdchk(eic_pkg::IDX_CH_IC0 + 16'h4, (m >= 2) ? 32'h0000_0080 : 32'h0, "fall flag");
        end
        wr(eic_pkg::IDX_CH_IC0 + 16'h4, 32'h0000_0000);
    endtask

    task automatic t_port3;
        wr(eic_pkg::IDX_P3X_IC, 32'h0000_017f);
        rdchk(eic_pkg::IDX_P3X_IC, 32'h0000_007f, "port3 fields");
        @(posedge clk) p3ev <= 1'b1;
        @(posedge clk) p3ev <= 1'b0;
        rdchk(eic_pkg::IDX_P3X_IC, 32'h0000_00ff, "port3 flag");
        wr(eic_pkg::IDX_P3X_IC, 32'h0000_0080);
        rdchk(eic_pkg::IDX_P3X_IC, 32'h0000_0080, "flag write");
        wr(eic_pkg::IDX_P3X_IC, 32'h0000_0000);
    endtask

    // Status, clear and enable of the level interrupt, plus an unmapped read
    task automatic t_irq;
        wr(eic_pkg::IDX_IRQ_CLEAR, 32'h0000_01ff);
        rdchk(eic_pkg::IDX_IRQ_STATUS, 32'h0000_0000, "status clear");
        wr(eic_pkg::IDX_IRQ_ENABLE, 32'h0000_0001);
        wr(eic_pkg::IDX_EDGE_SEL, 32'h0000_0001);
        @(posedge clk) port_pin[0] <= 1'b1;
        tick(3);
        chk_bit("irq raised", 1'b1, irq);
        wr(eic_pkg::IDX_IRQ_CLEAR, 32'h0000_0001);
        tick(2);
        chk_bit("irq cleared", 1'b0, irq);
        wr(eic_pkg::IDX_IRQ_ENABLE, 32'h0000_0000);
        @(posedge clk) port_pin[0] <= 1'b0;
        @(posedge clk) port_pin[0] <= 1'b1;
        tick(3);
        rdchk(eic_pkg::IDX_IRQ_STATUS, 32'h0000_0001, "status masked");
        chk_bit("irq masked", 1'b0, irq);
        rdchk(16'hf000, 32'h0000_0000, "unmapped read");
        @(posedge clk) port_pin[0] <= 1'b0;
        wr(eic_pkg::IDX_CH_IC0, 32'h0000_0000);
    endtask

    // Level beats level, disabled loses, group breaks a tie; then the model acks, slow then prompt
    task automatic t_arb;
        wr(eic_pkg::IDX_CH_IC0 + 16'h1, 32'h0000_00cc);
        wr(eic_pkg::IDX_CH_IC0 + 16'h2, 32'h0000_00d4);
        tick(3);
        chk_word("winner", 32'h0000_0025, {24'h0, int_src, int_level});
        wr(eic_pkg::IDX_CH_IC0 + 16'h2, 32'h0000_0094);
        tick(3);
        chk_word("winner", 32'h0000_0013, {24'h0, int_src, int_level});
        wr(eic_pkg::IDX_CH_IC0 + 16'h3, 32'h0000_00ce);
        tick(3);
        chk_word("winner", 32'h0000_000e, {26'h0, int_src, int_group});
        @(posedge clk);
        ack_wait <= 4'h3;
        ack_on   <= 1'b1;
        tick(30);
        chk_bit("request after acks", 1'b0, int_req);
        rdchk(eic_pkg::IDX_CH_IC0 + 16'h1, 32'h0000_004c, "acked flag");
        rdchk(eic_pkg::IDX_CH_IC0 + 16'h2, 32'h0000_0094, "disabled flag");
        @(posedge clk) ack_wait <= 4'h0;
        wr(eic_pkg::IDX_CH_IC0 + 16'h3, 32'h0000_00ce);
        tick(6);
        rdchk(eic_pkg::IDX_CH_IC0 + 16'h3, 32'h0000_004e, "prompt ack");
        chk_word("acked source", 32'h0000_0003, {28'h0, acked_src});
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        #300000;
        err_total++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        {clk, read, write, can1, can2, rtcs, rtca, p3ev, gpe, ack_on} = '0;
        {address, writedata, port_pin, mem_addr, ack_wait} = '0;
        byteenable = 4'hf;
        err_total  = 0;
        num_checks = 0;
        rstn       = 1'b0;
        tick(12);
        rstn <= 1'b1;
        t_reset();
        t_periph();
        t_select();
        t_alt();
        t_edge();
        t_port3();
        t_irq();
        t_arb();
        print_verdict();
    end
endmodule
